// file: core/nfc_consts.svh
`ifndef NFC_CONSTS_SVH
`define NFC_CONSTS_SVH

// Register byte offsets on the Wishbone side
`define NFC_OFF_CTRL 8'h00
`define NFC_OFF_ADDR 8'h04
`define NFC_OFF_WDATA 8'h08
`define NFC_OFF_RDATA 8'h0c
`define NFC_OFF_STAT 8'h10
`define NFC_OFF_ISR 8'h14
`define NFC_OFF_IMR 8'h18
`define NFC_OFF_CFG 8'h1c

// Control register fields
`define NFC_CTRL_GO 0
`define NFC_CTRL_WRITE 1
`define NFC_CTRL_X16 2
`define NFC_CTRL_PDOWN 3
`define NFC_CTRL_WAIT_STS 4

// Status register fields
`define NFC_STAT_BUSY 0
`define NFC_STAT_RD_OK 1
`define NFC_STAT_WR_OK 2
`define NFC_STAT_STS 3

// Interrupt status and mask fields
`define NFC_IRQ_DONE 0
`define NFC_IRQ_STS_RISE 1
`define NFC_IRQ_STS_FALL 2
`define NFC_IRQ_REFUSED 3
`define NFC_IRQ_W 4

// Configuration fields: active select pattern, idle pattern, density code
`define NFC_CFG_CS_ACT_LO 0
`define NFC_CFG_CS_IDLE_LO 3
`define NFC_CFG_DENS_LO 6

// Reset values
`define NFC_CTRL_RST 5'h08
`define NFC_CFG_RST 8'hf8
`define NFC_IMR_RST 4'h0

// Clock period and pin timing, in ns
`define NFC_CLK_NS 5
`define NFC_SETUP_NS 10
`define NFC_ACC_NS 150
`define NFC_WP_NS 70
`define NFC_HOLD_NS 10
`define NFC_RST_READ_NS 210
`define NFC_RST_WRITE_NS 210

// Least times round up to whole cycles
`define NFC_CYC(ns) (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

// file: core/nfc_pkg.sv
package nfc_pkg;

    typedef enum logic [4:0] {
        NFC_IDLE = 5'h01,
        NFC_WAITRDY = 5'h02,
        NFC_SETUP = 5'h04,
        NFC_STROBE = 5'h08,
        NFC_HOLD = 5'h10
    } nfc_state_t;

    typedef logic [1:0] nfc_dens_t;

endpackage

// file: core/nfc_host.sv
`timescale 1ns/10ps
`include "nfc_consts.svh"
// Behaviour
// - Top address line follows chosen density
// - Only valid command writes start automation
// - Status pin may pulse on completion
// - Wait reset-to-read and reset-to-write delays
module nfc_host
    import nfc_pkg::*;
#(
    parameter int ADDR_W = 25
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK,
    output logic IRQ,
    output logic [ADDR_W-1:0] FLASH_ADDR,
    input wire logic [15:0] FLASH_DATA_I,
    output logic [15:0] FLASH_DATA_O,
    output logic FLASH_DATA_OE,
    output logic CHIP_SELECT_0,
    output logic CHIP_SELECT_1,
    output logic CHIP_SELECT_2,
    output logic OUT_EN_N,
    output logic WRITE_EN_N,
    output logic WIDTH_SEL_N,
    output logic RESET_POWERDOWN_N,
    input wire logic ACTIVITY_STATUS
);

    localparam logic [7:0] SETUP_CYC = 8'(`NFC_CYC(`NFC_SETUP_NS));
    localparam logic [7:0] ACC_CYC = 8'(`NFC_CYC(`NFC_ACC_NS));
    localparam logic [7:0] WP_CYC = 8'(`NFC_CYC(`NFC_WP_NS));
    localparam logic [7:0] HOLD_CYC = 8'(`NFC_CYC(`NFC_HOLD_NS));
    localparam logic [7:0] RD_WAKE_CYC = 8'(`NFC_CYC(`NFC_RST_READ_NS));
    localparam logic [7:0] WR_WAKE_CYC = 8'(`NFC_CYC(`NFC_RST_WRITE_NS));

    // Address lines A21..A24 exist; narrower or wider buses cannot be served
    if (ADDR_W < 22 || ADDR_W > 25) begin : g_bad_width
        $error("nfc_host: ADDR_W must be 22 to 25");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Keep only the address lines that the chosen density has
    function automatic logic [ADDR_W-1:0] dens_mask(input nfc_dens_t d);
        logic [ADDR_W-1:0] m;
        m = '1;
        for (int i = 22; i < ADDR_W; i++) begin
            if (i > 21 + int'(d)) begin
                m[i] = 1'b0;
            end
        end
        return m;
    endfunction

    // Merge written bytes under the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    logic ack_q;
    logic [31:0] dat_q;
    logic [4:0] ctrl_q;
    logic [31:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic [7:0] cfg_q;
    logic [`NFC_IRQ_W-1:0] isr_q;
    logic [`NFC_IRQ_W-1:0] imr_q;
    logic [`NFC_IRQ_W-1:0] ev_d;
    logic [3:0] stat_d;
    logic wr_acc;
    logic go_wr;
    nfc_state_t state_q;

    assign wr_acc = WB_CYC && WB_STB && WB_WE && ack_q;
    assign go_wr = wr_acc && WB_ADR == `NFC_OFF_CTRL && WB_SEL[0] && WB_DAT_I[`NFC_CTRL_GO];

    // Answer one cycle after the request; drop ack the cycle after
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= WB_CYC && WB_STB && !ack_q;
        end
    end

    // Read data is captured alongside ack; unmapped offsets read zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dat_q <= 32'h0;
        end else if (WB_CYC && WB_STB && !ack_q) begin
            case (WB_ADR)
                `NFC_OFF_CTRL: dat_q <= {27'h0, ctrl_q & 5'h1e};
                `NFC_OFF_ADDR: dat_q <= addr_q;
                `NFC_OFF_WDATA: dat_q <= {16'h0, wdata_q};
                `NFC_OFF_RDATA: dat_q <= {16'h0, rdata_q};
                `NFC_OFF_STAT: dat_q <= {28'h0, stat_d};
                `NFC_OFF_ISR: dat_q <= {28'h0, isr_q};
                `NFC_OFF_IMR: dat_q <= {28'h0, imr_q};
                `NFC_OFF_CFG: dat_q <= {24'h0, cfg_q};
                default: dat_q <= 32'h0;
            endcase
        end
    end

    assign WB_ACK = ack_q;
    assign WB_DAT_O = dat_q;

    // Software-written registers; go is a strobe and is not stored
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `NFC_CTRL_RST;
            addr_q <= 32'h0;
            wdata_q <= 16'h0;
            cfg_q <= `NFC_CFG_RST;
            imr_q <= `NFC_IMR_RST;
        end else if (wr_acc) begin
            case (WB_ADR)
                `NFC_OFF_CTRL: ctrl_q <= 5'(merge({27'h0, ctrl_q}, WB_DAT_I, WB_SEL)) & 5'h1e;
                `NFC_OFF_ADDR: addr_q <= merge(addr_q, WB_DAT_I, WB_SEL);
                `NFC_OFF_WDATA: wdata_q <= 16'(merge({16'h0, wdata_q}, WB_DAT_I, WB_SEL));
                `NFC_OFF_IMR: imr_q <= 4'(merge({28'h0, imr_q}, WB_DAT_I, WB_SEL));
                `NFC_OFF_CFG: cfg_q <= 8'(merge({24'h0, cfg_q}, WB_DAT_I, WB_SEL));
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    logic sts_q;
    logic [7:0] wake_q;
    logic rd_ok;
    logic wr_ok;
    logic [`NFC_IRQ_W-1:0] clr;

    // Status pin edges mark sequencer activity, in level or pulse mode
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sts_q <= 1'b1;
        end else begin
            sts_q <= ACTIVITY_STATUS;
        end
    end

    assign clr = (wr_acc && WB_ADR == `NFC_OFF_ISR && WB_SEL[0]) ?
                 WB_DAT_I[`NFC_IRQ_W-1:0] : '0;

    // Sticky bits; an event in the clearing cycle survives
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            isr_q <= '0;
        end else begin
            isr_q <= (isr_q & ~clr) | ev_d;
        end
    end

    assign IRQ = |(isr_q & imr_q);

    ////////////////////////////////////////////////////////////////////////////
    // Reset and power-down pin

    // Count up after release so reads and writes wait their own delay
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wake_q <= 8'h0;
        end else if (ctrl_q[`NFC_CTRL_PDOWN]) begin
            wake_q <= 8'h0;
        end else if (wake_q != 8'hff) begin
            wake_q <= wake_q + 8'h1;
        end
    end

    assign rd_ok = wake_q >= RD_WAKE_CYC;
    assign wr_ok = wake_q >= WR_WAKE_CYC;
    assign RESET_POWERDOWN_N = !ctrl_q[`NFC_CTRL_PDOWN];
    assign WIDTH_SEL_N = ctrl_q[`NFC_CTRL_X16];
    assign stat_d = {ACTIVITY_STATUS, wr_ok, rd_ok, state_q != NFC_IDLE};

    ////////////////////////////////////////////////////////////////////////////
    // Pin cycle sequencer

    logic [7:0] cnt_q;
    logic dir_q;
    logic x16_q;
    logic [ADDR_W-1:0] fa_q;
    logic [15:0] fd_q;
    logic fd_oe_q;
    logic sel_q;
    logic oe_n_q;
    logic we_n_q;
    logic [2:0] cs_act;
    logic [2:0] cs_idle;

    assign cs_act = cfg_q[`NFC_CFG_CS_ACT_LO +: 3];
    assign cs_idle = cfg_q[`NFC_CFG_CS_IDLE_LO +: 3];

    // Events raised by the sequencer and the status pin
    always_comb begin
        ev_d = '0;
        ev_d[`NFC_IRQ_DONE] = state_q == NFC_HOLD && cnt_q == 8'h1;
        ev_d[`NFC_IRQ_STS_RISE] = ACTIVITY_STATUS && !sts_q;
        ev_d[`NFC_IRQ_STS_FALL] = !ACTIVITY_STATUS && sts_q;
        ev_d[`NFC_IRQ_REFUSED] = go_wr && (state_q != NFC_IDLE || ctrl_q[`NFC_CTRL_PDOWN]);
    end

    // One access at a time; a go while busy or powered down is refused
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= NFC_IDLE;
            cnt_q <= 8'h0;
            dir_q <= 1'b0;
            x16_q <= 1'b0;
            fa_q <= '0;
            fd_q <= 16'h0;
            fd_oe_q <= 1'b0;
            sel_q <= 1'b0;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            rdata_q <= 16'h0;
        end else begin
            case (state_q)
                NFC_IDLE: begin
                    if (go_wr && !ctrl_q[`NFC_CTRL_PDOWN]) begin
                        dir_q <= WB_DAT_I[`NFC_CTRL_WRITE];
                        x16_q <= WB_DAT_I[`NFC_CTRL_X16]; // Same width as the pin
                        fa_q <= addr_q[ADDR_W-1:0] & dens_mask(cfg_q[`NFC_CFG_DENS_LO +: 2]);
                        if (WB_DAT_I[`NFC_CTRL_X16]) begin
                            fa_q[0] <= 1'b0;
                        end
                        fd_q <= WB_DAT_I[`NFC_CTRL_X16] ? wdata_q : {8'h0, wdata_q[7:0]};
                        state_q <= NFC_WAITRDY;
                    end
                end
                NFC_WAITRDY: begin
                    // Optionally hold off until the sequencer reports ready
                    if ((dir_q ? wr_ok : rd_ok) &&
                        (!ctrl_q[`NFC_CTRL_WAIT_STS] || ACTIVITY_STATUS)) begin
                        sel_q <= 1'b1;
                        cnt_q <= SETUP_CYC;
                        state_q <= NFC_SETUP;
                    end
                end
                NFC_SETUP: begin
                    cnt_q <= cnt_q - 8'h1;
                    if (cnt_q == 8'h1) begin
                        if (dir_q) begin
                            we_n_q <= 1'b0;
                            fd_oe_q <= 1'b1;
                            cnt_q <= WP_CYC;
                        end else begin
                            oe_n_q <= 1'b0;
                            cnt_q <= ACC_CYC;
                        end
                        state_q <= NFC_STROBE;
                    end
                end
                NFC_STROBE: begin
                    cnt_q <= cnt_q - 8'h1;
                    if (cnt_q == 8'h1) begin
                        if (!dir_q) begin
                            // Byte mode: upper lanes are not driven by the flash
                            rdata_q <= x16_q ? FLASH_DATA_I : {8'h0, FLASH_DATA_I[7:0]};
                        end
                        we_n_q <= 1'b1;
                        oe_n_q <= 1'b1;
                        cnt_q <= HOLD_CYC;
                        state_q <= NFC_HOLD;
                    end
                end
                NFC_HOLD: begin
                    // Data and address stay put past the strobe edge
                    cnt_q <= cnt_q - 8'h1;
                    if (cnt_q == 8'h1) begin
                        sel_q <= 1'b0;
                        fd_oe_q <= 1'b0;
                        state_q <= NFC_IDLE;
                    end
                end
                default: state_q <= NFC_IDLE;
            endcase
        end
    end

    assign FLASH_ADDR = fa_q;
    assign FLASH_DATA_O = fd_q;
    assign FLASH_DATA_OE = fd_oe_q;
    assign OUT_EN_N = oe_n_q;
    assign WRITE_EN_N = we_n_q;
    assign CHIP_SELECT_0 = sel_q ? cs_act[0] : cs_idle[0];
    assign CHIP_SELECT_1 = sel_q ? cs_act[1] : cs_idle[1];
    assign CHIP_SELECT_2 = sel_q ? cs_act[2] : cs_idle[2];

endmodule

// file: bench/nfc_host_sva.sv
`timescale 1ns/10ps
`include "nfc_consts.svh"
module nfc_host_sva #(
    parameter int ADDR_W = 25
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_ACK,
    input wire logic [ADDR_W-1:0] FLASH_ADDR,
    input wire logic [15:0] FLASH_DATA_O,
    input wire logic FLASH_DATA_OE,
    input wire logic OUT_EN_N,
    input wire logic WRITE_EN_N,
    input wire logic WIDTH_SEL_N,
    input wire logic RESET_POWERDOWN_N
);
    localparam int WAKE = `NFC_CYC(`NFC_RST_WRITE_NS);
    int wake_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////
    // Cycles since power-down release, saturating to keep it small
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wake_q <= 0;
        end else if (!RESET_POWERDOWN_N) begin
            wake_q <= 0;
        end else if (wake_q < WAKE) begin
            wake_q <= wake_q + 1;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_ack_single: assert property (WB_ACK |=> !WB_ACK)
        else $error("ack held too long");
    a_ack_answer: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
        else $error("ack late");
    a_pdown_quiet: assert property (!RESET_POWERDOWN_N |-> WRITE_EN_N && OUT_EN_N)
        else $error("strobe in power-down");
    a_wake_wait: assert property ($fell(WRITE_EN_N) || $fell(OUT_EN_N) |-> wake_q >= WAKE)
        else $error("access too soon after wake");
    a_we_width: assert property ($fell(WRITE_EN_N) |-> ##13 !WRITE_EN_N ##1 WRITE_EN_N)
        else $error("write pulse width wrong");
    a_oe_width: assert property ($fell(OUT_EN_N) |-> ##29 !OUT_EN_N ##1 OUT_EN_N)
        else $error("read strobe width wrong");
    a_write_hold: assert property (!WRITE_EN_N |-> FLASH_DATA_OE ##1
        $stable(FLASH_ADDR) && $stable(FLASH_DATA_O)) else $error("write data not held");
    a_word_addr: assert property (WIDTH_SEL_N && !(OUT_EN_N && WRITE_EN_N) |-> !FLASH_ADDR[0])
        else $error("A0 driven in word mode");
endmodule
bind nfc_host nfc_host_sva #(.ADDR_W(ADDR_W)) u_nfc_host_sva (.CLK(CLK), .RST_N(RST_N),
    .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_ACK(WB_ACK), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_DATA_O(FLASH_DATA_O), .FLASH_DATA_OE(FLASH_DATA_OE), .OUT_EN_N(OUT_EN_N),
    .WRITE_EN_N(WRITE_EN_N), .WIDTH_SEL_N(WIDTH_SEL_N), .RESET_POWERDOWN_N(RESET_POWERDOWN_N));

// file: bench/nfc_flash_model.sv
`timescale 1ns/10ps
module nfc_flash_model #(
    parameter int BUSY = 20,
    parameter int LOCKED_BLK = 1
) (
    input wire logic clk,
    input wire logic [2:0] cs,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic x16,
    input wire logic rp_n,
    input wire logic [24:0] addr,
    input wire logic [15:0] din,
    output logic [15:0] dout,
    output logic sts
);
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    logic we_q = 1'b1;
    int busy = 0;
    wire sel = (cs == 3'h0) && rp_n;
    wire drive = sel && !oe_n;
    wire [7:0] idx = addr[8:1];
    wire [7:0] rb = addr[0] ? mem[idx][15:8] : mem[idx][7:0];
    wire [15:0] rd = x16 ? mem[idx] : {8'h00, rb};
    // 128-Kbyte erase blocks; one block stays locked for the whole run
    wire [7:0] blk = addr[24:17];
    wire locked = (blk == 8'(LOCKED_BLK));
    ////////////////////////////////////////////////////////////////
    // Commit on the trailing edge of the write strobe, then stay busy
    always @(posedge clk) begin
        we_q <= we_n;
        if (!rp_n) begin
            busy <= 0;
        end else if (we_n && !we_q && sel && !locked) begin
            busy <= BUSY;
            if (x16) mem[idx] <= din;
            else if (addr[0]) mem[idx][15:8] <= din[7:0];
            else mem[idx][7:0] <= din[7:0];
        end else if (busy > 0) begin
            busy <= busy - 1;
        end
        if (drive) last <= rd;
    end
    // Released bus shows the inverse of its last value, not a held copy
    assign dout = drive ? rd : ~last;
    assign sts = (busy == 0);
endmodule

// file: bench/nfc_host_tb_top.sv
`timescale 1ns/10ps
`include "nfc_consts.svh"
module nfc_host_tb_top;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, dato, rdat;
    logic ack, irq, oe, oe_n, we_n, x16, rp_n, sts;
    logic [24:0] faddr, seen_addr;
    logic [15:0] fdo, mdo;
    logic [2:0] cs;
    int miscompares = 0;
    int samples_checked = 0;
    // Shared data pins: whoever enables wins
    wire [15:0] dbus = oe ? fdo : mdo;
    always #2.5 CLK = ~CLK;
    nfc_host u_nfc_host (.CLK(CLK), .RST_N(RST_N), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
        .WB_ADR(adr), .WB_SEL(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK(ack),
        .IRQ(irq), .FLASH_ADDR(faddr), .FLASH_DATA_I(dbus), .FLASH_DATA_O(fdo),
        .FLASH_DATA_OE(oe), .CHIP_SELECT_0(cs[0]), .CHIP_SELECT_1(cs[1]),
        .CHIP_SELECT_2(cs[2]), .OUT_EN_N(oe_n), .WRITE_EN_N(we_n), .WIDTH_SEL_N(x16),
        .RESET_POWERDOWN_N(rp_n), .ACTIVITY_STATUS(sts));
    nfc_flash_model u_nfc_flash_model (.clk(CLK), .cs(cs), .oe_n(oe_n), .we_n(we_n),
        .x16(x16), .rp_n(rp_n), .addr(faddr), .din(dbus), .dout(mdo), .sts(sts));
    // Last address seen while the read strobe is low
    always @(posedge CLK) if (!oe_n) seen_addr <= faddr;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; held until ack is sampled, bounded wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge CLK);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dato;
        if (ack !== 1'b1) miscompares++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    // Poll busy until it drops; a hang counts as a mismatch
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, `NFC_OFF_STAT, 32'h0);
            n++;
        end while (rdat[`NFC_STAT_BUSY] !== 1'b0 && n < 100);
        if (rdat[`NFC_STAT_BUSY] !== 1'b0) miscompares++;
    endtask
    // Start a flash access and wait for it to finish
    task automatic acc(input logic [31:0] ctl, input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, `NFC_OFF_ADDR, a);
        bus(1'b1, `NFC_OFF_WDATA, d);
        bus(1'b1, `NFC_OFF_CTRL, ctl);
        wait_idle();
    endtask
    task automatic frd(input logic [31:0] ctl, a, exp, mask);
        acc(ctl, a, 32'h0);
        bus(1'b0, `NFC_OFF_RDATA, 32'h0);
        chk(rdat & mask, exp);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(`NFC_OFF_CTRL, 32'h08);
        rd(`NFC_OFF_CFG, 32'hf8);
        rd(`NFC_OFF_IMR, 32'h0);
        rd(8'h20, 32'h0);
        chk(rp_n, 32'h0);
    endtask
    task automatic t_refused();
        bus(1'b1, `NFC_OFF_CTRL, 32'h0b);
        rd(`NFC_OFF_ISR, 32'h8);
        bus(1'b1, `NFC_OFF_ISR, 32'hf);
        rd(`NFC_OFF_ISR, 32'h0);
    endtask
    // Word write, then byte and word views of the same cell
    task automatic t_width();
        bus(1'b1, `NFC_OFF_CTRL, 32'h0);
        // The pin is decoded from the register and changes as the write lands; wait one edge
        @(posedge CLK);
        chk(rp_n, 32'h1);
        acc(32'h17, 32'h20, 32'hbeef);
        frd(32'h05, 32'h20, 32'hbeef, 32'hffff);
        frd(32'h01, 32'h21, 32'hbe, 32'hff);
        frd(32'h01, 32'h20, 32'hef, 32'hff);
        acc(32'h03, 32'h21, 32'h5a);
        frd(32'h05, 32'h21, 32'h5aef, 32'hffff);
    endtask
    task automatic t_irq();
        int n;
        n = 0;
        bus(1'b1, `NFC_OFF_ISR, 32'hf);
        bus(1'b1, `NFC_OFF_IMR, 32'h1);
        acc(32'h13, 32'h40, 32'h12);
        chk(irq, 32'h1);
        do begin
            bus(1'b0, `NFC_OFF_ISR, 32'h0);
            n++;
        end while (rdat[`NFC_IRQ_STS_RISE] !== 1'b1 && n < 40);
        chk(rdat, 32'h7);
        bus(1'b1, `NFC_OFF_ISR, 32'h1);
        rd(`NFC_OFF_ISR, 32'h6);
        chk(irq, 32'h0);
        bus(1'b1, `NFC_OFF_IMR, 32'h2);
        rd(`NFC_OFF_IMR, 32'h2);
        chk(irq, 32'h1);
        bus(1'b1, `NFC_OFF_ISR, 32'hf);
        rd(`NFC_OFF_ISR, 32'h0);
        chk(irq, 32'h0);
        // A second go while the byte read still runs is refused
        bus(1'b1, `NFC_OFF_CTRL, 32'h01);
        bus(1'b1, `NFC_OFF_CTRL, 32'h01);
        rd(`NFC_OFF_ISR, 32'h8);
        wait_idle();
        rd(`NFC_OFF_RDATA, 32'h12);
    endtask
    // Density 64 Mbit: lines above the top one stay low
    task automatic t_density();
        bus(1'b1, `NFC_OFF_CFG, 32'h78);
        frd(32'h05, 32'h1800020, 32'h5aef, 32'hffff);
        chk(seen_addr, 32'h20);
        // Locked block aliases the same model cell; the cell must keep its value
        acc(32'h07, 32'h20020, 32'h1234);
        frd(32'h05, 32'h20, 32'h5aef, 32'hffff);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        t_reset();
        t_refused();
        t_width();
        t_irq();
        t_density();
        stop_test();
    end
    // Whole run is well under a thousand cycles; this cuts a hang short
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule
